// ### design/sfirq_pkg.sv
// package: register map, field layout and reset values of the supply fault block
package sfirq_pkg;

   // ****************************************
   // register indices and byte addresses
   // ****************************************
   // printed offsets are not multiples of four: keep index, address = 4*index
   localparam logic [15:0] SFIRQ_IDX_FLAGS_REG = 16'h4013;
   localparam logic [15:0] SFIRQ_IDX_FLAGS_CONV = 16'h4014;
   localparam logic [15:0] SFIRQ_IDX_MASKS_REG = 16'h401B;
   localparam logic [15:0] SFIRQ_IDX_MASKS_CONV = 16'h401C;
   localparam logic [15:0] SFIRQ_IDX_PGSEL_CONV = 16'h408E;
   localparam logic [15:0] SFIRQ_IDX_PGSEL_REG = 16'h408F;
   localparam logic [15:0] SFIRQ_IDX_THRESH = 16'h4090;
   localparam logic [15:0] SFIRQ_IDX_LIVE = 16'h4091;

   // ****************************************
   // field layout
   // ****************************************
   localparam int SFIRQ_NREG = 10;
   localparam int SFIRQ_NCONV = 4;
   localparam int SFIRQ_HC1_BIT = 8;
   localparam int SFIRQ_HC2_BIT = 9;
   localparam int SFIRQ_THR_W = 4;
   localparam int SFIRQ_THR1_LSB = 0;
   localparam int SFIRQ_THR2_LSB = 8;
   localparam int SFIRQ_LIVE_CONV_LSB = 12;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [9:0] SFIRQ_RST_MASK_REG = 10'h3FF;
   localparam logic [3:0] SFIRQ_RST_MASK_CONV = 4'hF;
   localparam logic [1:0] SFIRQ_RST_MASK_HC = 2'h3;
   localparam logic [3:0] SFIRQ_RST_PGSEL_CONV = 4'h7;
   localparam logic [9:0] SFIRQ_RST_PGSEL_REG = 10'h3FF;
   localparam logic [3:0] SFIRQ_RST_THR = 4'h0;

   // raw supply conditions travel together
   typedef struct packed {
      logic [SFIRQ_NREG-1:0] regUv;
      logic [SFIRQ_NCONV-1:0] convUv;
      logic [1:0] convHc;
   } sfirq_cond_t;

   // per-supply good-select bits
   typedef struct packed {
      logic [SFIRQ_NREG-1:0] reg_;
      logic [SFIRQ_NCONV-1:0] conv;
   } sfirq_sel_t;

endpackage

// ### design/sfirq_edge_flags.sv
// sticky rising-edge flag bank with write-one-to-clear
`timescale 1ns/1ps
module sfirq_edge_flags #(
   parameter int WIDTH = 4
) (
   input wire logic mclk, // register clock
   input wire logic rst, // synchronous reset, active high
   input wire logic [WIDTH-1:0] cond, // synchronised condition levels
   input wire logic [WIDTH-1:0] clrOnes, // write-one-to-clear strobe bits
   output logic [WIDTH-1:0] flags // sticky flags
);

   // refuse an empty bank while elaborating, before any logic is built
   if (WIDTH < 1) begin : gBadWidth
      $error("sfirq_edge_flags: WIDTH must be at least 1");
   end

   logic [WIDTH-1:0] condPrev_q;
   logic [WIDTH-1:0] flags_q;
   logic [WIDTH-1:0] rise;

   // remember last level so only a rising edge sets a flag
   always_ff @(posedge mclk) begin
      if (rst) begin
         condPrev_q <= '0;
      end else begin
         condPrev_q <= cond;
      end
   end

   assign rise = cond & ~condPrev_q;

   // set wins over a clear in the same cycle so no event is lost
   always_ff @(posedge mclk) begin
      if (rst) begin
         flags_q <= '0;
      end else begin
         flags_q <= (flags_q & ~clrOnes) | rise;
      end
   end

   assign flags = flags_q;

   chk_edge_sets_flag: assert property (@(posedge mclk)
      disable iff (rst)
      (cond & ~condPrev_q) != '0 |=> (flags_q & $past(rise)) == $past(rise))
      else $error("rising condition did not set its flag");

   chk_zero_write_keeps: assert property (@(posedge mclk)
      disable iff (rst)
      clrOnes == '0 |=> (flags_q & $past(flags_q)) == $past(flags_q))
      else $error("flag dropped without a clearing write");

endmodule

// ### design/sfirq_supply_fault.sv
// supply fault interrupt and power-good aggregation with an APB slave
//
// Contract
// - separate undervoltage flag per supply
// - unmasked undervoltage flag raises undervoltage irq
// - overcurrent flags only for converters one, two
// - unmasked overcurrent flag raises overcurrent irq
// - programmable current threshold field for converters one, two
// - overcurrent detection only flags, alters nothing
// - rising edge sets; write one clears
// - per-flag mask, one blocks, resets one
// - masked flag still records its event
// - regulator flags/masks in bits 9:0
// - converter bits 3:0, overcurrent 9, 8
// - power-good only on pin configured for it
// - per-supply select includes supply in power-good
// - power-good only while selected supplies good
// - any selected undervoltage drops power-good
// - shut-down supply presents no fault to power-good; its undervoltage flag still sets
// - select resets: conv1-3, regs one; conv4 zero
`timescale 1ns/1ps
module sfirq_supply_fault
   import sfirq_pkg::*;
#(
   parameter int NREG = SFIRQ_NREG,
   parameter int NCONV = SFIRQ_NCONV
) (
   input wire logic mclk, // register clock, 200 MHz
   input wire logic rst, // synchronous reset, active high
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [19:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   input wire logic [NREG-1:0] regUvRaw, // regulator undervoltage, async
   input wire logic [NCONV-1:0] convUvRaw, // converter undervoltage, async
   input wire logic [1:0] convHcRaw, // conv1/2 over threshold, async
   input wire logic [NREG-1:0] regOff, // regulator shut down, async
   input wire logic [NCONV-1:0] convOff, // converter shut down, async
   input wire logic pinIsGood, // pin set to power-good function
   output logic primaryUndervoltageIrq, // to top interrupt logic
   output logic primaryOvercurrentIrq, // to top interrupt logic
   output logic [SFIRQ_THR_W-1:0] conv1CurrentThreshold, // to comparator
   output logic [SFIRQ_THR_W-1:0] conv2CurrentThreshold, // to comparator
   output logic suppliesGoodOutput, // aggregated power-good on pin
   output logic suppliesGoodOe // pin driven while function selected
);

   // ****************************************
   // elaboration checks
   // ****************************************
   if (NREG != SFIRQ_NREG || NCONV != SFIRQ_NCONV) begin : gBadCount
      $error("sfirq_supply_fault: register layout fixes supply counts");
   end

   // ****************************************
   // input synchronisers
   // ****************************************
   localparam int NSYN = NREG + NCONV + 2 + NREG + NCONV + 1;
   logic [NSYN-1:0] syncA_q;
   logic [NSYN-1:0] syncB_q;
   sfirq_cond_t cond;
   logic [NREG-1:0] regOffS;
   logic [NCONV-1:0] convOffS;
   logic pinIsGoodS;

   // two stages before any logic looks at a pin
   always_ff @(posedge mclk) begin
      if (rst) begin
         syncA_q <= '0;
         syncB_q <= '0;
      end else begin
         syncA_q <= {pinIsGood, convOff, regOff, convHcRaw, convUvRaw,
                     regUvRaw};
         syncB_q <= syncA_q;
      end
   end

   assign cond.regUv = syncB_q[NREG-1:0];
   assign cond.convUv = syncB_q[NREG+NCONV-1:NREG];
   assign cond.convHc = syncB_q[NREG+NCONV+1:NREG+NCONV];
   assign regOffS = syncB_q[2*NREG+NCONV+1:NREG+NCONV+2];
   assign convOffS = syncB_q[2*NREG+2*NCONV+1:2*NREG+NCONV+2];
   assign pinIsGoodS = syncB_q[NSYN-1];

   // ****************************************
   // apb decode
   // ****************************************
   logic wrEn;
   logic rdEn;
   logic [17:0] widx;
   logic hit;

   function automatic logic idxIs(input logic [17:0] i,
                                  input logic [15:0] r);
      idxIs = (i == {2'b00, r});
   endfunction

   assign widx = paddr[19:2];
   assign hit = idxIs(widx, SFIRQ_IDX_FLAGS_REG)
              | idxIs(widx, SFIRQ_IDX_FLAGS_CONV)
              | idxIs(widx, SFIRQ_IDX_MASKS_REG)
              | idxIs(widx, SFIRQ_IDX_MASKS_CONV)
              | idxIs(widx, SFIRQ_IDX_PGSEL_CONV)
              | idxIs(widx, SFIRQ_IDX_PGSEL_REG)
              | idxIs(widx, SFIRQ_IDX_THRESH)
              | idxIs(widx, SFIRQ_IDX_LIVE);
   // access phase acts only while pready is low, so one strobe per transfer
   assign wrEn = psel & penable & ~pready & pwrite & hit;
   assign rdEn = psel & penable & ~pready & ~pwrite;

   // ****************************************
   // sticky flags
   // ****************************************
   logic [NREG-1:0] clrReg;
   logic [NCONV+2-1:0] clrConv;
   logic [NREG-1:0] regFlags;
   logic [NCONV+2-1:0] convFlags; // {hc2, hc1, uv[3:0]}

   assign clrReg = (wrEn && idxIs(widx, SFIRQ_IDX_FLAGS_REG))
                 ? pwdata[NREG-1:0] : '0;
   assign clrConv = (wrEn && idxIs(widx, SFIRQ_IDX_FLAGS_CONV))
                  ? {pwdata[SFIRQ_HC2_BIT], pwdata[SFIRQ_HC1_BIT],
                     pwdata[NCONV-1:0]} : '0;

   // one flag per regulator
   sfirq_edge_flags #(.WIDTH(NREG)) regFlagBank (
      .mclk(mclk),
      .rst(rst),
      .cond(cond.regUv),
      .clrOnes(clrReg),
      .flags(regFlags)
   );

   // converters plus the two overcurrent monitors
   sfirq_edge_flags #(.WIDTH(NCONV+2)) convFlagBank (
      .mclk(mclk),
      .rst(rst),
      .cond({cond.convHc, cond.convUv}),
      .clrOnes(clrConv),
      .flags(convFlags)
   );

   // ****************************************
   // control registers
   // ****************************************
   logic [NREG-1:0] regMask_q;
   logic [NCONV-1:0] convMask_q;
   logic [1:0] hcMask_q;
   sfirq_sel_t goodSel_q;
   logic [SFIRQ_THR_W-1:0] thr1_q;
   logic [SFIRQ_THR_W-1:0] thr2_q;

   // masks come up blocking every flag
   always_ff @(posedge mclk) begin
      if (rst) begin
         regMask_q <= SFIRQ_RST_MASK_REG;
         convMask_q <= SFIRQ_RST_MASK_CONV;
         hcMask_q <= SFIRQ_RST_MASK_HC;
      end else begin
         if (wrEn && idxIs(widx, SFIRQ_IDX_MASKS_REG)) begin
            regMask_q <= pwdata[NREG-1:0];
         end
         if (wrEn && idxIs(widx, SFIRQ_IDX_MASKS_CONV)) begin
            convMask_q <= pwdata[NCONV-1:0];
            hcMask_q <= {pwdata[SFIRQ_HC2_BIT], pwdata[SFIRQ_HC1_BIT]};
         end
      end
   end

   // power-good selects; converter four left out by default
   always_ff @(posedge mclk) begin
      if (rst) begin
         goodSel_q.conv <= SFIRQ_RST_PGSEL_CONV;
         goodSel_q.reg_ <= SFIRQ_RST_PGSEL_REG;
      end else begin
         if (wrEn && idxIs(widx, SFIRQ_IDX_PGSEL_CONV)) begin
            goodSel_q.conv <= pwdata[NCONV-1:0];
         end
         if (wrEn && idxIs(widx, SFIRQ_IDX_PGSEL_REG)) begin
            goodSel_q.reg_ <= pwdata[NREG-1:0];
         end
      end
   end

   // thresholds only steer the comparators, never the converter itself
   always_ff @(posedge mclk) begin
      if (rst) begin
         thr1_q <= SFIRQ_RST_THR;
         thr2_q <= SFIRQ_RST_THR;
      end else if (wrEn && idxIs(widx, SFIRQ_IDX_THRESH)) begin
         thr1_q <= pwdata[SFIRQ_THR1_LSB +: SFIRQ_THR_W];
         thr2_q <= pwdata[SFIRQ_THR2_LSB +: SFIRQ_THR_W];
      end
   end

   assign conv1CurrentThreshold = thr1_q;
   assign conv2CurrentThreshold = thr2_q;

   // ****************************************
   // primary interrupts
   // ****************************************
   logic uvIrq_q;
   logic hcIrq_q;

   // masking gates only the path onward; flags keep recording
   always_ff @(posedge mclk) begin
      if (rst) begin
         uvIrq_q <= 1'b0;
         hcIrq_q <= 1'b0;
      end else begin
         uvIrq_q <= |(regFlags & ~regMask_q)
                  | |(convFlags[NCONV-1:0] & ~convMask_q);
         hcIrq_q <= |(convFlags[NCONV+1:NCONV] & ~hcMask_q);
      end
   end

   assign primaryUndervoltageIrq = uvIrq_q;
   assign primaryOvercurrentIrq = hcIrq_q;

   // ****************************************
   // power good
   // ****************************************
   logic [NREG-1:0] regBad;
   logic [NCONV-1:0] convBad;
   logic good_q;
   logic goodOe_q;

   // a supply switched off no longer counts as a fault
   assign regBad = cond.regUv & ~regOffS & goodSel_q.reg_;
   assign convBad = cond.convUv & ~convOffS & goodSel_q.conv;

   // empty selection gives no bad term, so the output reads good while the pin is configured;
   // overcurrent never enters here, it is monitoring only
   always_ff @(posedge mclk) begin
      if (rst) begin
         good_q <= 1'b0;
         goodOe_q <= 1'b0;
      end else begin
         good_q <= pinIsGoodS & ~(|regBad) & ~(|convBad);
         goodOe_q <= pinIsGoodS;
      end
   end

   assign suppliesGoodOutput = good_q;
   assign suppliesGoodOe = goodOe_q;

   // ****************************************
   // apb read and answer
   // ****************************************
   logic [31:0] rdMux;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   // read mux; unused bits read as zero
   always_comb begin
      rdMux = 32'h0000_0000;
      if (idxIs(widx, SFIRQ_IDX_FLAGS_REG)) begin
         rdMux[NREG-1:0] = regFlags;
      end else if (idxIs(widx, SFIRQ_IDX_FLAGS_CONV)) begin
         rdMux[NCONV-1:0] = convFlags[NCONV-1:0];
         rdMux[SFIRQ_HC1_BIT] = convFlags[NCONV];
         rdMux[SFIRQ_HC2_BIT] = convFlags[NCONV+1];
      end else if (idxIs(widx, SFIRQ_IDX_MASKS_REG)) begin
         rdMux[NREG-1:0] = regMask_q;
      end else if (idxIs(widx, SFIRQ_IDX_MASKS_CONV)) begin
         rdMux[NCONV-1:0] = convMask_q;
         rdMux[SFIRQ_HC1_BIT] = hcMask_q[0];
         rdMux[SFIRQ_HC2_BIT] = hcMask_q[1];
      end else if (idxIs(widx, SFIRQ_IDX_PGSEL_CONV)) begin
         rdMux[NCONV-1:0] = goodSel_q.conv;
      end else if (idxIs(widx, SFIRQ_IDX_PGSEL_REG)) begin
         rdMux[NREG-1:0] = goodSel_q.reg_;
      end else if (idxIs(widx, SFIRQ_IDX_THRESH)) begin
         rdMux[SFIRQ_THR1_LSB +: SFIRQ_THR_W] = thr1_q;
         rdMux[SFIRQ_THR2_LSB +: SFIRQ_THR_W] = thr2_q;
      end else if (idxIs(widx, SFIRQ_IDX_LIVE)) begin
         rdMux[NREG-1:0] = cond.regUv;
         rdMux[SFIRQ_LIVE_CONV_LSB +: NCONV] = cond.convUv;
      end
   end

   // one wait state: pready rises the cycle after the access phase opens
   always_ff @(posedge mclk) begin
      if (rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= psel & penable & ~pready_q;
         pslverr_q <= psel & penable & ~pready_q & ~hit;
         if (rdEn) begin
            prdata_q <= hit ? rdMux : 32'h0000_0000;
         end
      end
   end

   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;

   // ****************************************
   // checks
   // ****************************************
   sequence sqUvPending;
      (|(regFlags & ~regMask_q)) || (|(convFlags[NCONV-1:0] & ~convMask_q));
   endsequence

   chk_uv_irq_follows: assert property (@(posedge mclk)
      disable iff (rst)
      sqUvPending |=> uvIrq_q)
      else $error("unmasked undervoltage flag did not raise irq");

   chk_uv_irq_cause: assert property (@(posedge mclk)
      disable iff (rst)
      uvIrq_q |-> $past(|(regFlags & ~regMask_q)
                     | |(convFlags[NCONV-1:0] & ~convMask_q)))
      else $error("undervoltage irq without an unmasked flag");

   chk_hc_irq_match: assert property (@(posedge mclk)
      disable iff (rst)
      ##1 hcIrq_q == $past(|(convFlags[NCONV+1:NCONV] & ~hcMask_q)))
      else $error("overcurrent irq disagrees with flags and masks");

   chk_mask_blocks: assert property (@(posedge mclk)
      disable iff (rst)
      (&regMask_q && &convMask_q) [*2] |-> !uvIrq_q)
      else $error("fully masked undervoltage still raised irq");

   chk_good_drops: assert property (@(posedge mclk)
      disable iff (rst)
      (|regBad || |convBad) |=> !good_q)
      else $error("power-good stayed up with a selected fault");

   chk_good_empty_sel: assert property (@(posedge mclk)
      disable iff (rst)
      (goodSel_q == '0 && pinIsGoodS) |=> good_q)
      else $error("power-good low with nothing selected");

   chk_pin_gate: assert property (@(posedge mclk)
      disable iff (rst)
      !pinIsGoodS |=> !good_q && !goodOe_q)
      else $error("power-good driven on unconfigured pin");

   chk_reset_sel: assert property (@(posedge mclk)
      $past(rst) |-> goodSel_q.conv == SFIRQ_RST_PGSEL_CONV
                     && regMask_q == SFIRQ_RST_MASK_REG)
      else $error("select or mask reset value wrong");

   chk_apb_beat: assert property (@(posedge mclk) disable iff (rst)
      (psel && penable && !pready) |=> pready ##1 !pready)
      else $error("apb answer not exactly one cycle later");

endmodule

// ### sim/sfirq_host_model.sv
// host-side model: watches the power-good pin as the processor sees it
`timescale 1ns/1ps
module sfirq_host_model (
   input wire logic mclk, // register clock
   input wire logic rst, // synchronous reset, active high
   input wire logic goodPin, // power-good level on the pin
   output int goodDrops // power-good deassertions seen
);
   logic goodLast_q;

   // ****************************************
   // power-good drop detection
   // ****************************************
   // each drop is the cue for the host to go and read the flags;
   // the bench does that read, this model only counts the cues
   always_ff @(posedge mclk) begin
      if (rst) begin
         goodLast_q <= 1'b0;
         goodDrops <= 0;
      end else begin
         goodLast_q <= goodPin;
         if (goodLast_q && !goodPin) begin
            goodDrops <= goodDrops + 1;
         end
      end
   end
endmodule

// ### sim/test_sfirq_supply_fault.sv
// self-checking bench for the supply fault interrupt and power-good block
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin numErrors++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module test_sfirq_supply_fault
   import sfirq_pkg::*;
();
   logic mclk, rst, psel, penable, pwrite, pinIsGood, err;
   logic pready, pslverr, uvIrq, hcIrq, good, goodOe;
   logic [19:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0] regUvRaw, regOff;
   logic [3:0] convUvRaw, convOff, thr1, thr2;
   logic [1:0] convHcRaw;
   int numErrors, nTests, goodDrops;
   wire logic pinLevel;

   // the pin is pulled down while the block does not drive it
   assign pinLevel = goodOe ? good : 1'b0;

   sfirq_supply_fault sfirq_supply_fault_i (
      .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .regUvRaw(regUvRaw),
      .convUvRaw(convUvRaw), .convHcRaw(convHcRaw), .regOff(regOff),
      .convOff(convOff), .pinIsGood(pinIsGood),
      .primaryUndervoltageIrq(uvIrq), .primaryOvercurrentIrq(hcIrq),
      .conv1CurrentThreshold(thr1), .conv2CurrentThreshold(thr2),
      .suppliesGoodOutput(good), .suppliesGoodOe(goodOe)
   );

   sfirq_host_model sfirq_host_model_i (
      .mclk(mclk), .rst(rst), .goodPin(pinLevel), .goodDrops(goodDrops)
   );

   // ****************************************
   // clock, verdict and watchdog
   // ****************************************
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic stopTest;
      $display("errors %0d checks %0d", numErrors, nTests);
      if (numErrors == 0 && nTests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // the tests need a few hundred cycles; this is ample slack
   initial begin
      repeat (20000) @(posedge mclk);
      numErrors++;
      stopTest();
   end

   // ****************************************
   // apb master
   // ****************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // one transfer; result left in rd and err
   task automatic apb(input logic w, input logic [15:0] idx,
      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= 20'({idx, 2'b00});
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
   endtask

   task automatic rdchk(input logic [15:0] idx, input logic [31:0] e);
      apb(1'b0, idx, 32'h0);
      `CHK(rd, e)
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic testReset;
      rdchk(SFIRQ_IDX_MASKS_REG, 32'h3FF);
      rdchk(SFIRQ_IDX_MASKS_CONV, 32'h30F);
      rdchk(SFIRQ_IDX_PGSEL_CONV, 32'h7);
      rdchk(SFIRQ_IDX_PGSEL_REG, 32'h3FF);
      rdchk(SFIRQ_IDX_FLAGS_CONV, 32'h0);
      `CHK(err, 1'b0)
      rdchk(16'h4020, 32'h0);
      `CHK(err, 1'b1)
      `CHK({uvIrq, hcIrq, thr1, thr2}, 10'h0)
   endtask

   task automatic testUv;
      @(posedge mclk);
      regUvRaw <= 10'h201;
      convUvRaw <= 4'h8;
      cyc(6);
      rdchk(SFIRQ_IDX_FLAGS_REG, 32'h201);
      rdchk(SFIRQ_IDX_FLAGS_CONV, 32'h8);
      `CHK(uvIrq, 1'b0)
      wr(SFIRQ_IDX_MASKS_REG, 32'h1FF);
      cyc(2);
      `CHK(uvIrq, 1'b1)
      wr(SFIRQ_IDX_FLAGS_REG, 32'h0);
      rdchk(SFIRQ_IDX_FLAGS_REG, 32'h201);
      // level still high: clearing must not re-set the flag
      wr(SFIRQ_IDX_FLAGS_REG, 32'h200);
      cyc(2);
      rdchk(SFIRQ_IDX_FLAGS_REG, 32'h1);
      `CHK(uvIrq, 1'b0)
      regUvRaw <= 10'h0;
      cyc(4);
      regUvRaw <= 10'h200;
      cyc(6);
      `CHK(uvIrq, 1'b1)
      regUvRaw <= 10'h0;
      convUvRaw <= 4'h0;
      wr(SFIRQ_IDX_FLAGS_REG, 32'h3FF);
      wr(SFIRQ_IDX_FLAGS_CONV, 32'h30F);
      cyc(2);
      `CHK(uvIrq, 1'b0)
   endtask

   task automatic testHc;
      @(posedge mclk);
      convHcRaw <= 2'b11;
      cyc(6);
      rdchk(SFIRQ_IDX_FLAGS_CONV, 32'h300);
      `CHK(hcIrq, 1'b0)
      wr(SFIRQ_IDX_MASKS_CONV, 32'h20F);
      cyc(2);
      `CHK({hcIrq, uvIrq}, 2'b10)
      `CHK({thr1, thr2}, 8'h00)
      wr(SFIRQ_IDX_THRESH, 32'hA05);
      cyc(1);
      `CHK({thr1, thr2}, 8'h5A)
      rdchk(SFIRQ_IDX_THRESH, 32'hA05);
      wr(SFIRQ_IDX_FLAGS_CONV, 32'h100);
      cyc(2);
      `CHK(hcIrq, 1'b0)
      rdchk(SFIRQ_IDX_FLAGS_CONV, 32'h200);
      convHcRaw <= 2'b00;
   endtask

   task automatic testGood;
      `CHK({goodOe, pinLevel}, 2'b00)
      pinIsGood <= 1'b1;
      cyc(5);
      `CHK({goodOe, pinLevel}, 2'b11)
      convUvRaw <= 4'h8;
      cyc(5);
      `CHK(pinLevel, 1'b1)
      regUvRaw <= 10'h001;
      cyc(5);
      `CHK(pinLevel, 1'b0)
      `CHK(goodDrops, 1)
      rdchk(SFIRQ_IDX_FLAGS_REG, 32'h1);
      regOff <= 10'h001;
      cyc(5);
      `CHK(pinLevel, 1'b1)
      wr(SFIRQ_IDX_PGSEL_CONV, 32'h8);
      cyc(5);
      `CHK(pinLevel, 1'b0)
      wr(SFIRQ_IDX_PGSEL_CONV, 32'h0);
      wr(SFIRQ_IDX_PGSEL_REG, 32'h0);
      cyc(3);
      `CHK(pinLevel, 1'b1)
      pinIsGood <= 1'b0;
      cyc(5);
      `CHK({goodOe, pinLevel}, 2'b00)
   endtask

   // reset in mid-run brings selects and masks back to their defaults
   task automatic testMidReset;
      wr(SFIRQ_IDX_PGSEL_CONV, 32'hF);
      wr(SFIRQ_IDX_MASKS_REG, 32'h0);
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      cyc(1);
      `CHK({uvIrq, hcIrq, goodOe}, 3'b000)
      rdchk(SFIRQ_IDX_PGSEL_CONV, 32'h7);
      rdchk(SFIRQ_IDX_MASKS_REG, 32'h3FF);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 20'h0;
      pwdata = 32'h0;
      regUvRaw = 10'h0;
      regOff = 10'h0;
      convUvRaw = 4'h0;
      convOff = 4'h0;
      convHcRaw = 2'h0;
      pinIsGood = 1'b0;
      numErrors = 0;
      nTests = 0;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      testReset();
      testUv();
      testHc();
      testGood();
      testMidReset();
      cyc(2);
      stopTest();
   end
endmodule
